// ===== core/ect_defs.svh
// Constants and field values for the event counter channel.
// How it works
// - Channels 0 and 1 count single-phase only; channels 2 to 4 add two-phase.
// - Single-phase source: input pin on chosen edge, or a timer overflow.
// - Single-phase direction comes from the select pin or a software bit.
// - Overflow or underflow reloads the counter unless free-run is chosen.
// - Set value n divides by FFFF-n+1 counting up, n+1 counting down.
// - Counting runs while the start flag is 1 and halts when it is 0.
// - Every overflow or underflow raises an interrupt request.
// - The count input pin is a general port or the counted signal input.
// - The toggle pin is a general port, pulse output or direction input.
// - Reading the count register gives the current counter value.
// - A write while stopped loads both reload register and counter.
// - A write while counting loads only the reload register until next reload.
// - Free-run skips the reload on overflow or underflow and keeps counting.
// - Pulse output inverts the toggle pin at every underflow.
// - Two-phase mode takes quadrature pulses on both pins for direction.
// - In two-phase mode every overflow or underflow reloads and restarts.
// - Normal two-phase: with toggle pin high, input rise counts up, fall down.
// - Times-four two-phase counts every edge of both pins with phase direction.
// - The counter is 16 bits wide.
`ifndef ECT_DEFS_SVH
`define ECT_DEFS_SVH
`define ECT_CNT_W      16
`define ECT_CNT_MAX    16'hffff
`define ECT_CNT_ZERO   16'h0000
`define ECT_CNT_STEP   16'h0001
`define ECT_CNT_RST    16'h0000
`define ECT_FIRST_QUAD 2
`define ECT_SYNC_DEPTH 2
`endif

// ===== core/ect_pkg.sv
// Types shared by the event counter channel and its helpers.
package ect_pkg;
    typedef enum logic [1:0] {
        ECT_SRC_PIN,
        ECT_SRC_B_OVF,
        ECT_SRC_A_OVF
    } ect_src_t;
    typedef struct packed {
        logic     start;
        ect_src_t src;
        logic     fall_edge;
        logic     ext_dir;
        logic     down_sw;
        logic     free_run;
        logic     pulse_out;
        logic     two_phase;
        logic     mul4;
        logic     cin_count;
        logic     tog_port_oe;
        logic     tog_port_val;
    } ect_cfg_t;
endpackage : ect_pkg

// ===== core/ect_sync.sv
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/1ns
`default_nettype none
module ect_sync #(
    parameter int W = 2
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    import ect_pkg::*;
    logic [W-1:0] meta_r;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_r <= '0;
            q_out  <= '0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule : ect_sync
`default_nettype wire

// ===== core/ect_quad.sv
// Quadrature decoder giving one-cycle up and down count pulses.
`timescale 1ns/1ns
`default_nettype none
module ect_quad (
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic en_in,
    input  wire logic mul4_in,
    input  wire logic a_in,
    input  wire logic b_in,
    output logic      inc_out,
    output logic      dec_out
);
    import ect_pkg::*;
    logic [1:0] prev_r;
    logic [1:0] cur;

    // Returns 1 for a step in the up direction of the {a,b} gray cycle.
    function automatic logic step_up(input logic [1:0] p, input logic [1:0] c);
        step_up = (p == 2'h1 && c == 2'h3) || (p == 2'h3 && c == 2'h2) ||
                  (p == 2'h2 && c == 2'h0) || (p == 2'h0 && c == 2'h1);
    endfunction : step_up

    assign cur = {a_in, b_in};

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prev_r <= 2'h0;
        end else begin
            prev_r <= cur;
        end
    end

    always_comb begin
        inc_out = 1'b0;
        dec_out = 1'b0;
        if (en_in && mul4_in) begin
            inc_out = step_up(prev_r, cur);
            dec_out = step_up(cur, prev_r);
        end else if (en_in && b_in && prev_r[1] != a_in) begin
            inc_out = a_in;
            dec_out = ~a_in;
        end
    end
endmodule : ect_quad
`default_nettype wire

// ===== core/ect_event_counter.sv
// One event counter channel with reload, free-run, pulse output and quadrature.
`timescale 1ns/1ns
`default_nettype none
`include "ect_defs.svh"
module ect_event_counter #(
    parameter int CH_ID = 2
) (
    input  wire logic                    clk_in,
    input  wire logic                    srst_in,
    input  wire ect_pkg::ect_cfg_t       cfg_in,
    input  wire logic                    wr_en_in,
    input  wire logic [`ECT_CNT_W-1:0]   wr_data_in,
    input  wire logic                    count_input_pin_in,
    input  wire logic                    toggle_output_pin_in,
    input  wire logic                    second_b_group_timer_ovf_in,
    input  wire logic                    neighbour_a_group_timer_ovf_in,
    output logic [`ECT_CNT_W-1:0]        count_out,
    output logic [`ECT_CNT_W-1:0]        reload_out,
    output logic                         irq_out,
    output logic                         toggle_output_pin_out,
    output logic                         toggle_output_pin_oe_out,
    output logic                         count_input_level_out,
    output logic                         toggle_input_level_out
);
    import ect_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [`ECT_CNT_W-1:0] cnt_r;
    logic [`ECT_CNT_W-1:0] reload_r;
    logic [1:0]            pins_s;
    logic                  cin_s;
    logic                  tog_s;
    logic                  cin_d_r;
    logic                  two_ph;
    logic                  dir_in_mode;
    logic                  pulse_mode;
    logic                  port_mode;
    logic                  q_inc;
    logic                  q_dec;
    logic                  rise;
    logic                  fall;
    logic                  single_tick;
    logic                  tick;
    logic                  up;
    logic                  wrap_up;
    logic                  wrap_dn;
    logic                  wrap;
    logic                  do_reload;
    logic                  run_tick;
    logic [`ECT_CNT_W-1:0] cnt_nxt;
    logic                  tog_r;
    logic                  oe_r;
    logic                  irq_r;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    ect_sync #(
        .W (`ECT_SYNC_DEPTH)
    ) u_sync (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .d_in    ({count_input_pin_in, toggle_output_pin_in}),
        .q_out   (pins_s)
    );

    assign cin_s = pins_s[1];
    assign tog_s = pins_s[0];

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cin_d_r <= 1'b0;
        end else begin
            cin_d_r <= cin_s;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Two-phase mode exists only on the upper channels.
    assign two_ph      = cfg_in.two_phase && (CH_ID >= `ECT_FIRST_QUAD);
    assign dir_in_mode = two_ph || cfg_in.ext_dir;
    assign pulse_mode  = !dir_in_mode && cfg_in.pulse_out;
    assign port_mode   = !dir_in_mode && !cfg_in.pulse_out;

    // ------------------------------------------------------------
    // Quadrature decoding
    // ------------------------------------------------------------
    ect_quad u_quad (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .en_in   (two_ph),
        .mul4_in (cfg_in.mul4),
        .a_in    (cin_s),
        .b_in    (tog_s),
        .inc_out (q_inc),
        .dec_out (q_dec)
    );

    // ------------------------------------------------------------
    // Count source and direction
    // ------------------------------------------------------------
    assign rise = cin_s && !cin_d_r;
    assign fall = !cin_s && cin_d_r;

    always_comb begin
        single_tick = 1'b0;
        unique case (cfg_in.src)
            ECT_SRC_PIN: begin
                // A pin left as a general port never counts.
                single_tick = cfg_in.cin_count && (cfg_in.fall_edge ? fall : rise);
            end
            ECT_SRC_B_OVF: begin
                single_tick = second_b_group_timer_ovf_in;
            end
            ECT_SRC_A_OVF: begin
                single_tick = neighbour_a_group_timer_ovf_in;
            end
            default: begin
                single_tick = 1'b0;
            end
        endcase
    end

    always_comb begin
        if (two_ph) begin
            tick = q_inc || q_dec;
            up   = q_inc;
        end else begin
            tick = single_tick;
            // Select pin high counts up, low counts down.
            up   = cfg_in.ext_dir ? tog_s : !cfg_in.down_sw;
        end
    end

    // ------------------------------------------------------------
    // Wrap detection
    // ------------------------------------------------------------
    assign run_tick  = cfg_in.start && tick;
    assign wrap_up   = run_tick && up && (cnt_r == `ECT_CNT_MAX);
    assign wrap_dn   = run_tick && !up && (cnt_r == `ECT_CNT_ZERO);
    assign wrap      = wrap_up || wrap_dn;
    assign do_reload = wrap && (two_ph || !cfg_in.free_run);

    // ------------------------------------------------------------
    // Counter and reload register
    // ------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        if (wr_en_in && !cfg_in.start) begin
            cnt_nxt = wr_data_in;
        end else if (do_reload) begin
            // A write in the same cycle reaches the counter at once.
            cnt_nxt = wr_en_in ? wr_data_in : reload_r;
        end else if (run_tick) begin
            // Free-run wraps naturally through the 16-bit width.
            cnt_nxt = up ? cnt_r + `ECT_CNT_STEP : cnt_r - `ECT_CNT_STEP;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_r <= `ECT_CNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reload_r <= `ECT_CNT_RST;
        end else if (wr_en_in) begin
            reload_r <= wr_data_in;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= wrap;
        end
    end

    // ------------------------------------------------------------
    // Toggle pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tog_r <= 1'b0;
        end else if (pulse_mode) begin
            if (wrap_dn) begin
                tog_r <= ~tog_r;
            end
        end else begin
            tog_r <= cfg_in.tog_port_val;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= pulse_mode || (port_mode && cfg_in.tog_port_oe);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_out              <= `ECT_CNT_RST;
            reload_out             <= `ECT_CNT_RST;
            count_input_level_out  <= 1'b0;
            toggle_input_level_out <= 1'b0;
        end else begin
            count_out              <= cnt_nxt;
            reload_out             <= reload_r;
            count_input_level_out  <= cin_s;
            toggle_input_level_out <= tog_s;
        end
    end

    assign irq_out                  = irq_r;
    assign toggle_output_pin_out    = tog_r;
    assign toggle_output_pin_oe_out = oe_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_TWO_PHASE_CH: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (CH_ID < `ECT_FIRST_QUAD) |-> !two_ph
    ) else $error("Two-phase mode active on a single-phase channel.");

    AST_HALT: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (!cfg_in.start && !wr_en_in) |=> (cnt_r == $past(cnt_r))
    ) else $error("Counter moved while the start flag was clear.");

    AST_WR_STOPPED: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_en_in && !cfg_in.start) |=>
            (cnt_r == $past(wr_data_in)) && (reload_r == $past(wr_data_in))
    ) else $error("Stopped write did not load counter and reload.");

    AST_WR_RUN: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_en_in && cfg_in.start && !tick) |=>
            (cnt_r == $past(cnt_r)) && (reload_r == $past(wr_data_in))
    ) else $error("Running write disturbed the counter.");

    AST_UP_STEP: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (run_tick && up && !wrap && !wr_en_in) |=>
            (cnt_r == $past(cnt_r) + `ECT_CNT_STEP)
    ) else $error("Up count did not advance by one.");

    AST_DN_STEP: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (run_tick && !up && !wrap && !wr_en_in) |=>
            (cnt_r == $past(cnt_r) - `ECT_CNT_STEP)
    ) else $error("Down count did not step back by one.");

    AST_RELOAD: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wrap && !cfg_in.free_run && !wr_en_in) |=> (cnt_r == $past(reload_r))
    ) else $error("Wrap did not reload the counter.");

    AST_FREE_RUN: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wrap_up && cfg_in.free_run && !two_ph && !wr_en_in) |=>
            (cnt_r == `ECT_CNT_ZERO)
    ) else $error("Free-run overflow did not roll to zero.");

    AST_QUAD_RELOAD: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wrap && two_ph && !wr_en_in) |=> (cnt_r == $past(reload_r))
    ) else $error("Two-phase wrap did not reload.");

    AST_IRQ: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wrap |=> irq_out ##1 !irq_out || $past(wrap)
    ) else $error("Interrupt request missing after wrap.");

    AST_IRQ_CAUSE: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !wrap |=> !irq_out
    ) else $error("Interrupt request without overflow or underflow.");

    AST_TOGGLE: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (pulse_mode && wrap_dn) |=>
            (toggle_output_pin_out != $past(toggle_output_pin_out))
    ) else $error("Pulse output did not invert on underflow.");

    AST_READ: assert property (
        @(posedge clk_in) disable iff (srst_in)
        ##1 (count_out == cnt_r)
    ) else $error("Count read does not match the counter.");

    AST_DIR_INPUT: assert property (
        @(posedge clk_in) disable iff (srst_in)
        dir_in_mode |=> !toggle_output_pin_oe_out
    ) else $error("Toggle pin driven while it serves as an input.");

    AST_PIN_PORT: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (!two_ph && cfg_in.src == ECT_SRC_PIN && !cfg_in.cin_count) |-> !tick
    ) else $error("Count input counted while used as a general port.");

    AST_QUAD_NORMAL: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (two_ph && !cfg_in.mul4 && !tog_s) |-> !tick
    ) else $error("Normal two-phase counted with toggle pin low.");

    AST_QUAD_MUL4: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (two_ph && cfg_in.mul4 && $changed(tog_s) && $stable(cin_s)) |-> tick
    ) else $error("Times-four mode missed a toggle pin edge.");

    AST_RELOAD_WR: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_en_in |=> (reload_r == $past(wr_data_in))
    ) else $error("Write did not reach the reload register.");

    AST_SRC_TIMER: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (!two_ph && cfg_in.src == ECT_SRC_B_OVF) |-> (tick == second_b_group_timer_ovf_in)
    ) else $error("Timer overflow source not followed.");

    AST_DIR_SEL: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (!two_ph && cfg_in.ext_dir) |-> (up == tog_s)
    ) else $error("Direction does not follow the select pin.");

    AST_FREE_DN: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wrap_dn && cfg_in.free_run && !two_ph && !wr_en_in) |=> (cnt_r == `ECT_CNT_MAX)
    ) else $error("Free-run underflow did not roll to the maximum.");

    AST_OE_PULSE: assert property (
        @(posedge clk_in) disable iff (srst_in)
        pulse_mode |=> toggle_output_pin_oe_out
    ) else $error("Pulse output mode left the toggle pin undriven.");

endmodule : ect_event_counter
`default_nettype wire

// ===== testbench/ect_far_side.sv
// Far-side model: counted pin, direction pin and the two timer overflow sources.
`timescale 1ns/1ns
`default_nettype none
module ect_far_side (
    input  wire logic clk_in,
    input  wire logic tog_oe_in,
    input  wire logic tog_val_in,
    output var  logic cin_pin_out,
    output wire logic tog_pin_out,
    output var  logic b_ovf_out,
    output var  logic a_ovf_out
);
    logic b_drv_r = 1'b0;
    logic b_en_r = 1'b0;
    logic idle_r = 1'b0;
    initial begin
        cin_pin_out = 1'b0;
        b_ovf_out = 1'b0;
        a_ovf_out = 1'b0;
    end
    // An undriven toggle pin wanders so that a stale level is never mistaken for a drive.
    always @(negedge clk_in) idle_r <= ~idle_r;
    assign tog_pin_out = tog_oe_in ? tog_val_in : (b_en_r ? b_drv_r : idle_r);
    // Each high cycle is one event; gap 0 gives back-to-back events.
    task automatic ovf_pulses(input logic use_a, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            if (use_a) a_ovf_out = 1'b1;
            else b_ovf_out = 1'b1;
            @(negedge clk_in);
            if (gap > 0) begin
                a_ovf_out = 1'b0;
                b_ovf_out = 1'b0;
                repeat (gap) @(negedge clk_in);
            end
        end
        a_ovf_out = 1'b0;
        b_ovf_out = 1'b0;
    endtask : ovf_pulses
    task automatic pin_set(input logic v);
        cin_pin_out = v;
        repeat (6) @(negedge clk_in);
    endtask : pin_set
    task automatic pin_pulses(input int n);
        repeat (n) begin
            pin_set(1'b1);
            pin_set(1'b0);
        end
    endtask : pin_pulses
    // Bit 1 is the counted pin, bit 0 the toggle pin, both held long enough to pass sync.
    task automatic quad(input logic [1:0] ab);
        cin_pin_out = ab[1];
        b_drv_r = ab[0];
        b_en_r = 1'b1;
        repeat (6) @(negedge clk_in);
    endtask : quad
endmodule : ect_far_side
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for two event counter channels (CH_ID 2 and 0) and their far side.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ect_pkg::*;
    typedef struct packed {
        logic [2:0]  kind;
        logic [15:0] val;
    } ect_note_t;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        wr_en_in = 1'b0;
    logic [15:0] wr_data_in = 16'h0000;
    ect_cfg_t    cfg_in = '0;
    logic [15:0] count_out, reload_out, count0, rl0, d;
    logic        irq_out, tog_out, tog_oe, cin_lvl, tog_lvl, irq0, tog0, oe0, cl0, tl0;
    wire logic   cin_pin, tog_pin, b_ovf, a_ovf;
    int          miscompares = 0;
    int          total_checks = 0;
    int          irq_cnt = 0;
    int          irq_exp = 0;
    ect_note_t   exp_q[$];
    event        look;
    logic [1:0]  up_seq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    logic [1:0]  dn_seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};

    always #10 clk_in = ~clk_in;

    ect_event_counter #(.CH_ID(2)) uut (
        .clk_in(clk_in), .srst_in(srst_in), .cfg_in(cfg_in),
        .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
        .count_input_pin_in(cin_pin), .toggle_output_pin_in(tog_pin),
        .second_b_group_timer_ovf_in(b_ovf), .neighbour_a_group_timer_ovf_in(a_ovf),
        .count_out(count_out), .reload_out(reload_out), .irq_out(irq_out),
        .toggle_output_pin_out(tog_out), .toggle_output_pin_oe_out(tog_oe),
        .count_input_level_out(cin_lvl), .toggle_input_level_out(tog_lvl));
    ect_event_counter #(.CH_ID(0)) uut_ch0 (
        .clk_in(clk_in), .srst_in(srst_in), .cfg_in(cfg_in),
        .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
        .count_input_pin_in(cin_pin), .toggle_output_pin_in(tog_pin),
        .second_b_group_timer_ovf_in(b_ovf), .neighbour_a_group_timer_ovf_in(a_ovf),
        .count_out(count0), .reload_out(rl0), .irq_out(irq0), .toggle_output_pin_out(tog0),
        .toggle_output_pin_oe_out(oe0), .count_input_level_out(cl0),
        .toggle_input_level_out(tl0));
    ect_far_side far (
        .clk_in(clk_in), .tog_oe_in(tog_oe), .tog_val_in(tog_out),
        .cin_pin_out(cin_pin), .tog_pin_out(tog_pin), .b_ovf_out(b_ovf), .a_ovf_out(a_ovf));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    always @(posedge clk_in) begin
        if (srst_in) irq_cnt <= 0;
        else if (irq_out === 1'b1) irq_cnt <= irq_cnt + 1;
    end
    always @(look) begin
        ect_note_t n;
        #1;
        n = exp_q.pop_front();
        case (n.kind)
            3'h0: check(count_out, n.val);
            3'h1: check(16'(irq_cnt), n.val);
            3'h2: check({14'h0, tog_oe, tog_out}, n.val);
            3'h3: check(reload_out, n.val);
            3'h4: check(count0, n.val);
            3'h5: check({15'h0, cin_lvl}, n.val);
            3'h6: check({15'h0, tog_lvl}, n.val);
            default: check({rl0[10:0], irq0, tog0, oe0, cl0, tl0}, n.val);
        endcase
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        results();
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic note(input logic [2:0] k, input logic [15:0] v);
        exp_q.push_back('{k, v});
        -> look;
        cyc(1);
    endtask : note
    task automatic wr(input logic [15:0] v);
        wr_en_in = 1'b1;
        wr_data_in = v;
        cyc(1);
        wr_en_in = 1'b0;
    endtask : wr
    task automatic ev(input int n, input int gap);
        far.ovf_pulses(cfg_in.src == ECT_SRC_A_OVF, n, gap);
        cyc(3);
    endtask : ev
    task automatic wrapped;
        irq_exp++;
        note(1, 16'(irq_exp));
    endtask : wrapped

    initial begin
        void'($urandom(87418));
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        note(0, 16'h0000);
        note(2, 16'h0000);
        d = 16'($urandom);
        wr(d);
        note(0, d);
        note(3, d);
        for (int s = 1; s < 3; s++) begin
            cfg_in = '0;
            cfg_in.src = ect_src_t'(s);
            cfg_in.down_sw = 1'b1;
            wr(16'h0003);
            cfg_in.start = 1'b1;
            ev(3, 1);
            note(0, 16'h0000);
            ev(1, 1);
            note(0, 16'h0003);
            wrapped();
            cfg_in.start = 1'b0;
            ev(2, 1);
            note(0, 16'h0003);
        end
        d = 16'hfff0 | 16'($urandom_range(15));
        wr(d);
        cfg_in.down_sw = 1'b0;
        cfg_in.start = 1'b1;
        ev(int'(16'hffff - d), 0);
        note(0, 16'hffff);
        ev(1, 1);
        note(0, d);
        wrapped();
        cfg_in.start = 1'b0;
        wr(16'h0005);
        cfg_in.down_sw = 1'b1;
        cfg_in.start = 1'b1;
        ev(2, 1);
        wr(16'h0009);
        note(0, 16'h0003);
        note(3, 16'h0009);
        ev(4, 1);
        note(0, 16'h0009);
        wrapped();
        cfg_in.start = 1'b0;
        cfg_in.free_run = 1'b1;
        wr(16'h0001);
        cfg_in.start = 1'b1;
        ev(2, 1);
        note(0, 16'hffff);
        wrapped();
        cfg_in.down_sw = 1'b0;
        ev(1, 1);
        note(0, 16'h0000);
        wrapped();
        cfg_in = '0;
        cfg_in.src = ECT_SRC_B_OVF;
        cfg_in.pulse_out = 1'b1;
        cfg_in.down_sw = 1'b1;
        wr(16'h0001);
        note(2, 16'h0002);
        cfg_in.start = 1'b1;
        ev(2, 1);
        note(2, 16'h0003);
        wrapped();
        ev(2, 1);
        note(2, 16'h0002);
        wrapped();
        cfg_in.start = 1'b0;
        wr(16'hffff);
        cfg_in.down_sw = 1'b0;
        cfg_in.start = 1'b1;
        ev(1, 1);
        note(2, 16'h0002);
        wrapped();
        cfg_in = '0;
        cfg_in.tog_port_oe = 1'b1;
        cfg_in.tog_port_val = 1'($urandom);
        cyc(2);
        note(2, {15'h1, cfg_in.tog_port_val});
        cfg_in.tog_port_oe = 1'b0;
        cyc(2);
        note(2, {15'h0, cfg_in.tog_port_val});
        cfg_in.cin_count = 1'b1;
        wr(16'h0010);
        cfg_in.start = 1'b1;
        far.pin_pulses(3);
        note(0, 16'h0013);
        cfg_in.fall_edge = 1'b1;
        far.pin_set(1'b1);
        note(0, 16'h0013);
        far.pin_set(1'b0);
        note(0, 16'h0014);
        cfg_in.cin_count = 1'b0;
        far.pin_set(1'b1);
        note(5, 16'h0001);
        far.pin_set(1'b0);
        note(0, 16'h0014);
        cfg_in = '0;
        cfg_in.src = ECT_SRC_B_OVF;
        cfg_in.ext_dir = 1'b1;
        cfg_in.down_sw = 1'b1;
        cfg_in.start = 1'b1;
        far.quad(2'b01);
        note(6, 16'h0001);
        ev(2, 1);
        note(0, 16'h0016);
        far.quad(2'b00);
        note(6, 16'h0000);
        ev(1, 1);
        note(0, 16'h0015);
        cfg_in = '0;
        cfg_in.two_phase = 1'b1;
        wr(16'h0003);
        cfg_in.start = 1'b1;
        far.quad(2'b01);
        note(0, 16'h0003);
        far.quad(2'b11);
        note(0, 16'h0004);
        far.quad(2'b01);
        note(0, 16'h0003);
        far.quad(2'b00);
        far.quad(2'b10);
        far.quad(2'b00);
        note(0, 16'h0003);
        cfg_in.mul4 = 1'b1;
        for (int i = 0; i < 8; i++) far.quad(up_seq[i % 4]);
        note(0, 16'h000b);
        for (int i = 0; i < 8; i++) far.quad(dn_seq[i % 4]);
        note(0, 16'h0003);
        note(4, 16'h0003);
        note(7, 16'h0060);
        cfg_in.free_run = 1'b1;
        for (int i = 0; i < 4; i++) far.quad(dn_seq[i]);
        note(0, 16'h0003);
        wrapped();
        cyc(2);
        results();
    end
endmodule : testbench
`default_nettype wire
